/* File: rtl/sclc_params.svh */
// Field positions, reset values and codes of the channel clock and line register
`ifndef SCLC_PARAMS_SVH
`define SCLC_PARAMS_SVH

// ------------------------------------------------------------
// Register placement (channel 0 byte offset)
// ------------------------------------------------------------
`define SCLC_CFG_OFFSET     12'h15C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SCLC_X4_BIT         14
`define SCLC_RXINV_BIT      13
`define SCLC_TXINV_BIT      12
`define SCLC_RCS_HI         11
`define SCLC_RCS_LO         10
`define SCLC_TCS_HI         9
`define SCLC_TCS_LO         7
`define SCLC_BCS_HI         6
`define SCLC_BCS_LO         4
`define SCLC_CLOCK_ON_RTS_ENABLE_BIT     3
`define SCLC_MODE_HI        2
`define SCLC_MODE_LO        0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SCLC_RCS_RST        2'h0
`define SCLC_TCS_RST        3'h0
`define SCLC_BCS_RST        3'h0
`define SCLC_MODE_RST       3'h7

// ------------------------------------------------------------
// Field codes
// ------------------------------------------------------------
`define SCLC_RCS_BAUD       2'h0
`define SCLC_RCS_RXPIN      2'h1
`define SCLC_RCS_DPLL       2'h2
`define SCLC_TCS_BAUD       3'h0
`define SCLC_TCS_RXPIN      3'h1
`define SCLC_TCS_TXPIN      3'h2
`define SCLC_TCS_DPLL       3'h3
`define SCLC_TCS_BAUD16     3'h4
`define SCLC_BCS_OSC1       3'h0
`define SCLC_BCS_OSC2       3'h1
`define SCLC_BCS_OSC3       3'h2
`define SCLC_BCS_RXPIN      3'h3
`define SCLC_BCS_TXPIN      3'h4
`define SCLC_MODE_V35       3'h4
`define SCLC_MODE_V28       3'h6
`define SCLC_MODE_HIZ       3'h7

// ------------------------------------------------------------
// Counts
// ------------------------------------------------------------
`define SCLC_BAUD_DIV       16
`define SCLC_WORD_BITS      32

`endif

/* File: rtl/sclc_pkg.sv */
// Types shared by the channel clock and line configuration block
package sclc_pkg;

	// ------------------------------------------------------------
	// Line electrical standard
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SCLC_LINE_V11,
		SCLC_LINE_V35,
		SCLC_LINE_V28,
		SCLC_LINE_HIZ
	} sclc_line_t;

endpackage

/* File: rtl/sclc_div.sv */
// Edge counting divider giving a level at an even fraction of its input
`timescale 1ns/1ps
module sclc_div #(
	parameter int DIV = 16
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic edge_en,
	output logic      div_q
);

	localparam int HALF = DIV / 2;
	localparam int CW   = $clog2(HALF) + 1;

	logic [CW-1:0] cnt_q;

	// ------------------------------------------------------------
	// Toggle every half period of rising input edges
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			div_q <= 1'b0;
		end else if (edge_en) begin
			if (cnt_q == CW'(HALF - 1)) begin
				cnt_q <= '0;
				div_q <= ~div_q;
			end else begin
				cnt_q <= cnt_q + CW'(1);
			end
		end
	end

endmodule

/* File: rtl/sclc_top.sv */
// Channel clock selection, clock polarity, line mode and byte order logic
//
// Contract
// RULE_01: Uninverted receive clock samples on falling edge
// RULE_02: Inverted receive clock samples on rising edge
// RULE_03: Uninverted transmit clock launches on rising edge
// RULE_04: Inverted transmit clock launches on falling edge
// RULE_05: Two-bit field picks receiver clock, resets zero
// RULE_06: Three-bit field picks transmitter clock source
// RULE_07: Software clears pin enable before using pin
// RULE_08: Three-bit field picks baud generator source
// RULE_09: Transmit clock drives request-to-send when enabled
// RULE_10: Mode field in bits 2:0, resets 111
// RULE_11: Modes pick V.11, V.28 or high impedance
// RULE_12: Mode 100 gives V.35 data, V.28 handshake
// RULE_13: Software keeps multiplier input 4.5 to 28 MHz
// RULE_14: Host bytes are little-endian on data lanes
// RULE_15: Lower transmit bytes are sent first
// RULE_16: Earlier received bytes stored at lower positions
// RULE_17: Multiply bit scales baud input by four
`timescale 1ns/1ps
`include "sclc_params.svh"
module sclc_top
	import sclc_pkg::*;
#(
	parameter int WORD_BITS = `SCLC_WORD_BITS,
	parameter int BAUD_DIV  = `SCLC_BAUD_DIV
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  wire logic                 reg_wr_en,
	input  wire logic                 reg_rd_en,
	input  wire logic [3:0]           reg_be,
	input  wire logic [31:0]          reg_wdata,
	output logic      [31:0]          reg_rdata,
	input  wire logic                 osc1_clk,
	input  wire logic                 osc2_clk,
	input  wire logic                 osc3_clk,
	input  wire logic                 baud_gen_out,
	input  wire logic                 dpll_rx_clk,
	input  wire logic                 dpll_tx_clk,
	input  wire logic                 rx_clock_pin,
	input  wire logic                 tx_clock_pin_in,
	output logic                      tx_clock_pin_out,
	output logic                      tx_clock_pin_output_enable,
	input  wire logic                 tx_clk_oe_req,
	input  wire logic                 rts_req,
	output logic                      rts_pin,
	input  wire logic                 rx_data,
	output logic                      tx_data,
	input  wire logic [WORD_BITS-1:0] tx_word,
	input  wire logic                 tx_word_valid,
	output logic                      tx_word_ready,
	output logic      [WORD_BITS-1:0] rx_word,
	output logic                      rx_word_valid,
	output logic                      baud_src_clk,
	output logic                      times_four_multiply,
	output sclc_line_t                line_data_std,
	output sclc_line_t                line_hs_std,
	output logic                      line_drv_enable
);

	localparam int CW = $clog2(WORD_BITS);

	// ------------------------------------------------------------
	// Configuration fields
	// ------------------------------------------------------------
	logic       x4_q;
	logic       rx_inv_q;
	logic       tx_inv_q;
	logic [1:0] rx_sel_q;
	logic [2:0] tx_sel_q;
	logic [2:0] bcs_q;
	logic       rts_clk_q;
	logic [2:0] mode_q;

	// Byte 0 sits on data bits 7:0, byte 1 on 15:8
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			x4_q      <= 1'b0;
			rx_inv_q  <= 1'b0;
			tx_inv_q  <= 1'b0;
			rx_sel_q  <= `SCLC_RCS_RST; // RULE_05
			tx_sel_q  <= `SCLC_TCS_RST;
			bcs_q     <= `SCLC_BCS_RST;
			rts_clk_q <= 1'b0;
			mode_q    <= `SCLC_MODE_RST; // RULE_10
		end else if (reg_wr_en) begin
			if (reg_be[0]) begin // RULE_14
				tx_sel_q[0] <= reg_wdata[`SCLC_TCS_LO];
				bcs_q       <= reg_wdata[`SCLC_BCS_HI:`SCLC_BCS_LO];
				rts_clk_q   <= reg_wdata[`SCLC_CLOCK_ON_RTS_ENABLE_BIT];
				mode_q      <= reg_wdata[`SCLC_MODE_HI:`SCLC_MODE_LO];
			end
			if (reg_be[1]) begin // RULE_14
				x4_q          <= reg_wdata[`SCLC_X4_BIT];
				rx_inv_q      <= reg_wdata[`SCLC_RXINV_BIT];
				tx_inv_q      <= reg_wdata[`SCLC_TXINV_BIT];
				rx_sel_q      <= reg_wdata[`SCLC_RCS_HI:`SCLC_RCS_LO];
				tx_sel_q[2:1] <= reg_wdata[`SCLC_TCS_HI:`SCLC_TCS_LO+1];
			end
		end
	end

	// Bits outside this block's fields read as zero
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd_en) begin
			reg_rdata <= {17'h0, x4_q, rx_inv_q, tx_inv_q, rx_sel_q, tx_sel_q,
				bcs_q, rts_clk_q, mode_q};
		end
	end

	// ------------------------------------------------------------
	// Clock source selection
	// ------------------------------------------------------------
	logic baud_q;
	logic div16_q;
	logic rx_raw;
	logic tx_raw;
	logic rx_raw_q;
	logic tx_raw_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			baud_q <= 1'b0;
		end else begin
			baud_q <= baud_gen_out;
		end
	end

	sclc_div #(
		.DIV (BAUD_DIV)
	) u_div16 (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.edge_en  (baud_gen_out & ~baud_q),
		.div_q    (div16_q)
	);

	// Reserved codes give a still clock, so nothing shifts
	always_comb begin
		if (rx_sel_q == `SCLC_RCS_BAUD) begin // RULE_05
			rx_raw = baud_gen_out;
		end else if (rx_sel_q == `SCLC_RCS_RXPIN) begin
			rx_raw = rx_clock_pin;
		end else if (rx_sel_q == `SCLC_RCS_DPLL) begin
			rx_raw = dpll_rx_clk;
		end else begin
			rx_raw = 1'b0;
		end
	end

	// Pin code relies on software having turned the pin to input
	always_comb begin
		if (tx_sel_q == `SCLC_TCS_BAUD) begin // RULE_06
			tx_raw = baud_gen_out;
		end else if (tx_sel_q == `SCLC_TCS_RXPIN) begin
			tx_raw = rx_clock_pin;
		end else if (tx_sel_q == `SCLC_TCS_TXPIN) begin // RULE_07
			tx_raw = tx_clock_pin_in;
		end else if (tx_sel_q == `SCLC_TCS_DPLL) begin
			tx_raw = dpll_tx_clk;
		end else if (tx_sel_q == `SCLC_TCS_BAUD16) begin
			tx_raw = div16_q;
		end else begin
			tx_raw = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			baud_src_clk <= 1'b0;
		end else if (bcs_q == `SCLC_BCS_OSC1) begin // RULE_08
			baud_src_clk <= osc1_clk;
		end else if (bcs_q == `SCLC_BCS_OSC2) begin
			baud_src_clk <= osc2_clk;
		end else if (bcs_q == `SCLC_BCS_OSC3) begin
			baud_src_clk <= osc3_clk;
		end else if (bcs_q == `SCLC_BCS_RXPIN) begin
			baud_src_clk <= rx_clock_pin;
		end else if (bcs_q == `SCLC_BCS_TXPIN) begin
			baud_src_clk <= tx_clock_pin_in;
		end else begin
			baud_src_clk <= 1'b0;
		end
	end

	// The multiplier itself is analog; this only steers it
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			times_four_multiply <= 1'b0;
		end else begin
			times_four_multiply <= x4_q; // RULE_17
		end
	end

	// ------------------------------------------------------------
	// Edge detection with polarity
	// ------------------------------------------------------------
	logic rx_sample;
	logic tx_launch;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rx_raw_q <= 1'b0;
			tx_raw_q <= 1'b0;
		end else begin
			rx_raw_q <= rx_raw;
			tx_raw_q <= tx_raw;
		end
	end

	assign rx_sample = rx_inv_q ? (~rx_raw_q & rx_raw) : (rx_raw_q & ~rx_raw); // RULE_01 RULE_02
	assign tx_launch = tx_inv_q ? (tx_raw_q & ~tx_raw) : (~tx_raw_q & tx_raw); // RULE_03 RULE_04

	// ------------------------------------------------------------
	// Receive word assembly
	// ------------------------------------------------------------
	logic [WORD_BITS-1:0] rx_sr_q;
	logic [CW-1:0]        rx_cnt_q;

	// Shifting in from the top puts the first byte in the low lane
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rx_sr_q       <= '0;
			rx_cnt_q      <= '0;
			rx_word       <= '0;
			rx_word_valid <= 1'b0;
		end else begin
			rx_word_valid <= 1'b0;
			if (rx_sample) begin
				rx_sr_q  <= {rx_data, rx_sr_q[WORD_BITS-1:1]}; // RULE_16
				rx_cnt_q <= rx_cnt_q + CW'(1);
				if (rx_cnt_q == CW'(WORD_BITS - 1)) begin
					rx_word       <= {rx_data, rx_sr_q[WORD_BITS-1:1]};
					rx_word_valid <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit word serializer
	// ------------------------------------------------------------
	logic [WORD_BITS-1:0] tx_sr_q;
	logic [CW-1:0]        tx_cnt_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_sr_q       <= '0;
			tx_cnt_q      <= '0;
			tx_data       <= 1'b1;
			tx_word_ready <= 1'b1;
		end else if (tx_word_ready) begin
			if (tx_word_valid) begin
				tx_sr_q       <= tx_word;
				tx_word_ready <= 1'b0;
			end
		end else if (tx_launch) begin
			tx_data  <= tx_sr_q[0]; // RULE_15
			tx_sr_q  <= {1'b0, tx_sr_q[WORD_BITS-1:1]};
			tx_cnt_q <= tx_cnt_q + CW'(1);
			if (tx_cnt_q == CW'(WORD_BITS - 1)) begin
				tx_word_ready <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Pins and line mode
	// ------------------------------------------------------------
	function automatic sclc_line_t line_std(input logic [2:0] mode, input logic hs);
		if (mode == `SCLC_MODE_HIZ) begin
			line_std = SCLC_LINE_HIZ;
		end else if (mode == `SCLC_MODE_V28) begin
			line_std = SCLC_LINE_V28;
		end else if (mode == `SCLC_MODE_V35) begin
			line_std = hs ? SCLC_LINE_V28 : SCLC_LINE_V35;
		end else begin
			line_std = SCLC_LINE_V11;
		end
	endfunction

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			line_data_std   <= SCLC_LINE_HIZ;
			line_hs_std     <= SCLC_LINE_HIZ;
			line_drv_enable <= 1'b0;
		end else begin
			line_data_std   <= line_std(mode_q, 1'b0); // RULE_11 RULE_12
			line_hs_std     <= line_std(mode_q, 1'b1); // RULE_11 RULE_12
			line_drv_enable <= (mode_q != `SCLC_MODE_HIZ); // RULE_11
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rts_pin                    <= 1'b0;
			tx_clock_pin_out           <= 1'b0;
			tx_clock_pin_output_enable <= 1'b0;
		end else begin
			rts_pin                    <= rts_clk_q ? tx_raw : rts_req; // RULE_09
			tx_clock_pin_out           <= tx_raw;
			tx_clock_pin_output_enable <= tx_clk_oe_req & (mode_q != `SCLC_MODE_HIZ);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_word_load;
		tx_word_ready && tx_word_valid;
	endsequence

	sequence s_tx_shift;
		!tx_word_ready && tx_launch;
	endsequence

	a_rx_fall_sample: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_01
		(!rx_inv_q && rx_raw_q && !rx_raw) |=> (rx_sr_q[WORD_BITS-1] == $past(rx_data)))
		else $error("receive bit not taken on falling edge");
	a_rx_rise_sample: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_02
		(rx_inv_q && !rx_raw_q && rx_raw) |=> (rx_sr_q[WORD_BITS-1] == $past(rx_data)))
		else $error("receive bit not taken on rising edge");
	a_tx_rise_launch: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_03
		(!tx_inv_q && !tx_raw_q && tx_raw && !tx_word_ready) |=> (tx_data == $past(tx_sr_q[0])))
		else $error("transmit bit not launched on rising edge");
	a_tx_fall_launch: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_04
		(tx_inv_q && tx_raw_q && !tx_raw) ##0 s_tx_shift |=> (tx_data == $past(tx_sr_q[0])))
		else $error("transmit bit not launched on falling edge");
	a_rx_clock_pick: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_05
		(rx_sel_q == `SCLC_RCS_RXPIN) |=> (rx_raw_q == $past(rx_clock_pin)))
		else $error("receive clock not from pin");
	a_tx_clock_div: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_06
		(tx_sel_q == `SCLC_TCS_BAUD16) |=> (tx_raw_q == $past(div16_q)))
		else $error("transmit clock not divided baud clock");
	a_baud_src_pick: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_08
		(bcs_q == `SCLC_BCS_RXPIN) |=> (baud_src_clk == $past(rx_clock_pin)))
		else $error("baud source not from receive pin");
	a_rts_clock_out: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_09
		rts_clk_q |=> (rts_pin == $past(tx_raw)))
		else $error("request-to-send not carrying transmit clock");
	a_line_hiz_mode: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_11
		(mode_q == `SCLC_MODE_HIZ) |=> (!line_drv_enable && line_data_std == SCLC_LINE_HIZ))
		else $error("drivers enabled in high impedance mode");
	a_line_v35_mode: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_12
		(mode_q == `SCLC_MODE_V35) |=> (line_data_std == SCLC_LINE_V35
			&& line_hs_std == SCLC_LINE_V28))
		else $error("wrong line standard in V.35 mode");
	a_host_byte_lane: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_14
		(reg_wr_en && reg_be == 4'h1) |=> (mode_q == $past(reg_wdata[2:0])
			&& rx_inv_q == $past(rx_inv_q)))
		else $error("byte lane zero not mapped to low bits");
	a_tx_word_load: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_15
		s_word_load |=> (tx_sr_q == $past(tx_word)) ##0 !tx_word_ready)
		else $error("transmit word not loaded low byte first");
	a_rx_word_order: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_16
		rx_word_valid |-> (rx_word[WORD_BITS-1] == $past(rx_data)
			&& rx_word[WORD_BITS-2:0] == $past(rx_sr_q[WORD_BITS-1:1])))
		else $error("receive word order wrong");
	a_x4_follow: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_17
		$rose(x4_q) |=> times_four_multiply)
		else $error("multiplier not enabled");

endmodule

/* File: test/sclc_line_model.sv */
// Far-side line equipment: framed clock, serial data in both directions
`timescale 1ns/1ps
module sclc_line_model #(
	parameter int HALF = 6
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic        idle_lvl,
	input  wire logic [31:0] word_in,
	input  wire logic        tx_data,
	output logic             line_clk,
	output logic             rx_data,
	output logic             busy,
	output logic [31:0]      tx_cap
);
	logic [31:0] sh_q;
	logic [4:0]  idx_q;
	logic [3:0]  cnt_q;

	// ------------------------------------------------------------
	// Frame of 32 periods, away edge launches, return edge samples
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			busy     <= 1'b0;
			line_clk <= 1'b0;
			rx_data  <= 1'b1;
			idx_q    <= '0;
			cnt_q    <= '0;
			sh_q     <= '0;
			tx_cap   <= '0;
		end else if (!busy) begin
			line_clk <= idle_lvl;
			rx_data  <= ~rx_data;
			if (start) begin
				busy    <= 1'b1;
				sh_q    <= word_in;
				idx_q   <= '0;
				cnt_q   <= '0;
				rx_data <= word_in[0];
			end
		end else if (cnt_q == 4'(HALF - 1)) begin
			cnt_q    <= '0;
			line_clk <= ~line_clk;
			if (line_clk != idle_lvl) begin
				tx_cap <= {tx_data, tx_cap[31:1]};
				idx_q  <= idx_q + 5'h1;
				if (idx_q == 5'h1F) begin
					busy <= 1'b0;
				end
			end else begin
				// Data moves half a period before the sampling edge
				rx_data <= sh_q[idx_q];
			end
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule

/* File: test/serial_channel_clock_and_line_config_test.sv */
// Self-checking bench for the channel clock and line configuration block
`timescale 1ns/1ps
module serial_channel_clock_and_line_config_test;
	import sclc_pkg::*;
	logic        core_clk, rst_n, reg_wr_en, reg_rd_en, osc1_clk, osc2_clk, osc3_clk;
	logic        baud_gen_out, dpll_rx_clk, dpll_tx_clk, tx_clock_pin_in, tx_clk_oe_req;
	logic        rts_req, tx_word_valid, line_clk, rx_data_w, tx_data, tx_pin_out, tx_oe;
	logic        rts_pin, tx_word_ready, rx_word_valid, baud_src_clk, x4, drv_en;
	logic        m_start, m_idle, m_busy, prev;
	logic [3:0]  reg_be;
	logic [31:0] reg_wdata, reg_rdata, tx_word, rx_word, m_word, m_cap, shadow, got, d;
	logic [7:0]  tsrc, bsrc;
	sclc_line_t  data_std, hs_std;
	int          err_count, checks, cyc, n;

	sclc_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.osc1_clk(osc1_clk), .osc2_clk(osc2_clk), .osc3_clk(osc3_clk),
		.baud_gen_out(baud_gen_out), .dpll_rx_clk(dpll_rx_clk), .dpll_tx_clk(dpll_tx_clk),
		.rx_clock_pin(line_clk), .tx_clock_pin_in(tx_clock_pin_in),
		.tx_clock_pin_out(tx_pin_out), .tx_clock_pin_output_enable(tx_oe),
		.tx_clk_oe_req(tx_clk_oe_req), .rts_req(rts_req), .rts_pin(rts_pin),
		.rx_data(rx_data_w), .tx_data(tx_data), .tx_word(tx_word),
		.tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready), .rx_word(rx_word),
		.rx_word_valid(rx_word_valid), .baud_src_clk(baud_src_clk),
		.times_four_multiply(x4), .line_data_std(data_std), .line_hs_std(hs_std),
		.line_drv_enable(drv_en));

	sclc_line_model u_line (.core_clk(core_clk), .rst_n(rst_n), .start(m_start),
		.idle_lvl(m_idle), .word_in(m_word), .tx_data(tx_data), .line_clk(line_clk),
		.rx_data(rx_data_w), .busy(m_busy), .tx_cap(m_cap));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic sclc_line_t exp_std(input logic [2:0] m, input logic hs);
		case (m)
			3'h4: return hs ? SCLC_LINE_V28 : SCLC_LINE_V35;
			3'h6: return SCLC_LINE_V28;
			3'h7: return SCLC_LINE_HIZ;
			default: return SCLC_LINE_V11;
		endcase
	endfunction

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [3:0] be, input logic [31:0] wd);
		reg_wr_en = 1'b1;
		reg_be    = be;
		reg_wdata = wd;
		tick(1);
		reg_wr_en = 1'b0;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) shadow[8*b +: 8] = wd[8*b +: 8];
		end
		shadow = shadow & 32'h0000_7FFF;
	endtask

	task automatic rd(output logic [31:0] rv);
		reg_rd_en = 1'b1;
		tick(1);
		reg_rd_en = 1'b0;
		rv = reg_rdata;
	endtask

	// One frame each way; idle level is moved while invert is still clear
	task automatic serial(input logic inv);
		m_idle = inv;
		tick(3);
		tx_clk_oe_req = 1'b0;
		wr(4'hF, {17'h0, 1'b0, inv, inv, 2'b01, 3'b001, 3'b000, 1'b0, 3'b000});
		tx_word = $urandom;
		m_word = $urandom;
		n = 0;
		while (tx_word_ready !== 1'b1 && n < 50) begin
			tick(1);
			n++;
		end
		tx_word_valid = 1'b1;
		tick(1);
		tx_word_valid = 1'b0;
		m_start = 1'b1;
		tick(1);
		m_start = 1'b0;
		got = 'x;
		n = 0;
		repeat (600) begin
			tick(1);
			if (rx_word_valid === 1'b1) got = rx_word;
			if (m_busy !== 1'b1 && n++ > 5) break;
		end
		check(got, m_word);
		check(m_cap, tx_word);
		check(tx_word_ready, 1'b1);
	endtask

	// ------------------------------------------------------------
	// Clock, reset, timeout
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			final_report();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n, reg_wr_en, reg_rd_en, osc1_clk, osc2_clk, osc3_clk, baud_gen_out} = '0;
		{dpll_rx_clk, dpll_tx_clk, tx_clock_pin_in, tx_clk_oe_req, rts_req} = '0;
		{tx_word_valid, m_start, m_idle, reg_be, reg_wdata, tx_word, m_word} = '0;
		err_count = 0;
		checks = 0;
		cyc = 0;
		shadow = 32'h0000_0007;
		void'($urandom(32'h80CF));
		repeat (12) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		rd(got);
		check(got, 32'h0000_0007);
		check(32'(data_std), 32'(SCLC_LINE_HIZ));
		check({drv_en, tx_data}, 2'b01);
		serial(1'b0);
		serial(1'b1);
		// Random writes with partial byte enables, every mode in turn
		for (int i = 0; i < 24; i++) begin
			d = $urandom;
			d[2:0] = i[2:0];
			if (d[14]) d[6:4] = 3'h0;
			tx_clk_oe_req = 1'b0;
			wr(4'($urandom) | 4'h1, d);
			tx_clk_oe_req = 1'($urandom) && shadow[9:7] != 3'h2 && shadow[6:4] != 3'h4;
			rd(got);
			tick(2);
			check(got, shadow);
			check(x4, shadow[14]);
			check(32'(data_std), 32'(exp_std(shadow[2:0], 1'b0)));
			check(32'(hs_std), 32'(exp_std(shadow[2:0], 1'b1)));
			check(drv_en, shadow[2:0] != 3'h7);
			check(tx_oe, tx_clk_oe_req && shadow[2:0] != 3'h7);
		end
		tx_clk_oe_req = 1'b0;
		// Source selection seen on the pin and baud generator input
		for (int c = 0; c < 8; c++) begin
			wr(4'h3, {17'h0, 3'b000, 2'b00, 3'(c), 3'(c), 1'b1, 3'b000});
			repeat (2) begin
				{osc1_clk, osc2_clk, osc3_clk, baud_gen_out} = 4'($urandom);
				{tx_clock_pin_in, dpll_tx_clk, dpll_rx_clk} = 3'($urandom);
				tick(3);
				tsrc = {4'h0, dpll_tx_clk, tx_clock_pin_in, line_clk, baud_gen_out};
				bsrc = {3'h0, tx_clock_pin_in, line_clk, osc3_clk, osc2_clk, osc1_clk};
				if (c != 4) check(rts_pin, tsrc[c]);
				if (c != 4) check(tx_pin_out, tsrc[c]);
				check(baud_src_clk, bsrc[c]);
			end
		end
		wr(4'h3, 32'h0000_0000);
		repeat (2) begin
			rts_req = 1'($urandom);
			tick(3);
			check(rts_pin, rts_req);
		end
		// Divided baud clock: 32 input edges give four pin changes
		// Start low so that the first pulse is a real rising edge
		baud_gen_out = 1'b0;
		wr(4'h3, {17'h0, 3'b000, 2'b00, 3'b100, 3'b000, 1'b1, 3'b000});
		tick(3);
		prev = rts_pin;
		n = 0;
		repeat (32) begin
			baud_gen_out = 1'b1;
			repeat (4) begin
				tick(1);
				if (rts_pin !== prev) n++;
				prev = rts_pin;
				baud_gen_out = 1'b0;
			end
		end
		repeat (4) begin
			tick(1);
			if (rts_pin !== prev) n++;
			prev = rts_pin;
		end
		check(n, 4);
		final_report();
	end
endmodule
